// ### rtl/sync_action_executor.sv
// per-axis synchronous action stage: trigger gating, actions, interrupt
// Functional notes
// [R1] fire selects fixed or continuous drive, plus or minus, from low action bits
// [R2] real-position load copies the 32-bit staged word into the real counter
// [R3] pulse-count load copies the 32-bit staged word into the pulse count
// [R4] interrupt action drives irq_out_n low and sets the axis sync flag; the pin goes low only while mask bit 9 is set
// [R5] host read of status three clears the sync flag and releases irq_out_n; an interrupt event in the same cycle keeps it set
// [R6] also stops, counter save to buffer, logical and speed load, pulse output
// [R7] host stages factor and action selections then writes mode command 64h
// [R8] each factor and other-axis bit enables its trigger when one
// [R9] logical read command 10h is a trigger so saves align across axes
`timescale 1ns/100ps
`include "sync_action_map.svh"
module sync_action_executor #(
   parameter int DATA_W = 32                          // counter width
) (
   input  wire logic              sys_clk,            // 100 MHz system clock
   input  wire logic              rst_n,              // synchronous reset, low
   input  wire logic [3:0]        reg_addr,           // register address
   input  wire logic [15:0]       reg_wdata,          // write data
   input  wire logic              reg_wr,             // write strobe
   input  wire logic              reg_rd,             // read strobe
   output logic      [15:0]       reg_rdata,          // read data, next cycle
   input  wire logic [7:0]        factor_events,      // own comparator/drive/in3 events
   input  wire logic [2:0]        other_axis_fire,    // fire pulses of the other three axes
   input  wire logic [DATA_W-1:0] logical_pos,        // logical position counter
   input  wire logic [DATA_W-1:0] real_pos,           // real position counter
   output logic                   sync_fire,          // this axis fired, pulse
   output logic                   fixed_drive_plus_action,       // drive start and stop pulses
   output logic                   fixed_drive_minus_action,
   output logic                   continuous_drive_plus_action,
   output logic                   continuous_drive_minus_action,
   output logic                   decel_stop_action,
   output logic                   instant_stop_action,
   output logic                   logical_pos_load_action,       // load strobes
   output logic                   real_pos_load_action,
   output logic                   pulse_count_load_action,
   output logic                   speed_load_action,
   output logic      [DATA_W-1:0] load_value,         // staged value for loads
   output logic                   sync_pulse_out,     // external sync pulse
   output logic                   irq_out_n           // interrupt, active low
);
   logic [15:0]       factor_q, factor_d;   // staging low word / factor select
   logic [15:0]       action_q, action_d;   // staging high word / action select
   logic [15:0]       fac_arm_q, fac_arm_d; // armed factor selection
   logic [15:0]       act_arm_q, act_arm_d; // armed action selection
   logic [15:0]       mask_q, mask_d;
   logic              sync_flag_q, sync_flag_d;
   logic [DATA_W-1:0] buffer_q, buffer_d;
   logic [15:0]       rdata_q, rdata_d;
   logic [15:0]       act_pulse_q, act_pulse_d;
   logic [DATA_W-1:0] load_q, load_d;
   sync_action_pkg::arm_state_type state_q, state_d;
   // staging and armed copies; arming is a snapshot, not a live link
   localparam int OWN_N = 10;               // own-axis trigger sources
   localparam int SRC_N = OWN_N + 3;        // plus three linked axes
   logic              fire;
   logic [OWN_N-1:0]  trig_src;
   logic [SRC_N-1:0]  src_hit;              // enabled sources seen this cycle
   logic              read_status;

   // trigger sources, each gated by its own armed factor bit
   always_comb begin
      trig_src[7:0] = factor_events;
      trig_src[8]   = reg_wr && reg_addr == `SYNC_ADDR_MODE_CMD
                      && reg_wdata[7:0] == `SYNC_CMD_LOGICAL_READ;  // [R9]
      trig_src[9]   = reg_wr && reg_addr == `SYNC_ADDR_MODE_CMD
                      && reg_wdata[7:0] != `SYNC_CMD_MODE_SET
                      && reg_wdata[7:0] != `SYNC_CMD_LOGICAL_READ;
   end

   // per-source gate: a factor bit written as zero silences its source
   // linked axes map onto factor bits 13 to 15 in order
   for (genvar g = 0; g < SRC_N; g++) begin : g_src
      if (g < OWN_N) begin : g_own
         assign src_hit[g] = trig_src[g] && fac_arm_q[g];                 // [R8]
      end else begin : g_link
         assign src_hit[g] = other_axis_fire[g-OWN_N]
                             && fac_arm_q[g-OWN_N+`FAC_OTHER_LO];         // [R8]
      end
   end

   // fire only while armed; reserved factor bits 10 to 12 never gate anything
   assign fire = (state_q == sync_action_pkg::ARM_READY) && (|src_hit);  // [R8]
   assign read_status = reg_rd && reg_addr == `SYNC_ADDR_STATUS_THREE;

   // register writes and arming, the host side of the block
   always_comb begin
      factor_d    = factor_q;
      action_d    = action_q;
      fac_arm_d   = fac_arm_q;
      act_arm_d   = act_arm_q;
      mask_d      = mask_q;
      state_d     = state_q;
      if (reg_wr) begin
         case (reg_addr)
            `SYNC_ADDR_FACTOR_LO: factor_d = reg_wdata;
            `SYNC_ADDR_ACTION_HI: action_d = reg_wdata;
            `SYNC_ADDR_MASK:      mask_d   = reg_wdata;
            `SYNC_ADDR_MODE_CMD: begin
               if (reg_wdata[7:0] == `SYNC_CMD_MODE_SET) begin
                  // selections latch from staging so later data writes are free
                  fac_arm_d = factor_q;                               // [R7]
                  act_arm_d = action_q;
                  state_d   = sync_action_pkg::ARM_READY;
               end
            end
            default: ;
         endcase
      end
   end

   // configuration registers; a fresh 64h write re-arms with new selections
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         factor_q    <= `SYNC_SEL_RESET;
         action_q    <= `SYNC_SEL_RESET;
         fac_arm_q   <= `SYNC_SEL_RESET;
         act_arm_q   <= `SYNC_SEL_RESET;
         mask_q      <= `SYNC_MASK_RESET;
         state_q     <= sync_action_pkg::ARM_IDLE;
      end else begin
         factor_q    <= factor_d;
         action_q    <= action_d;
         fac_arm_q   <= fac_arm_d;
         act_arm_q   <= act_arm_d;
         mask_q      <= mask_d;
         state_q     <= state_d;
      end
   end

   // action execution at the event; pulses fall back low in any cycle without an event
   always_comb begin
      buffer_d    = buffer_q;
      load_d      = load_q;
      act_pulse_d = '0;
      if (fire) begin
         act_pulse_d = act_arm_q;                                     // [R1] [R6]
         if (act_arm_q[`ACT_LOGICAL_SAVE])
            buffer_d = logical_pos;                                   // [R6]
         else if (act_arm_q[`ACT_REAL_SAVE])
            buffer_d = real_pos;
         // staged word is taken as it stands at the event
         if (act_arm_q[`ACT_SPEED_LOAD] && !(|act_arm_q[10:8]))
            load_d = DATA_W'(factor_q);
         else
            load_d = DATA_W'({action_q, factor_q});                  // [R2] [R3]
      end
   end

   // action pulses, save buffer and load word
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         buffer_q    <= '0;
         load_q      <= '0;
         act_pulse_q <= '0;
      end else begin
         buffer_q    <= buffer_d;
         load_q      <= load_d;
         act_pulse_q <= act_pulse_d;
      end
   end

   // sticky sync flag: an event in the clearing read cycle wins
   always_comb begin
      sync_flag_d = sync_flag_q;
      if (read_status)
         sync_flag_d = 1'b0;                                          // [R5]
      if (fire && act_arm_q[`ACT_IRQ])
         sync_flag_d = 1'b1;                                          // [R4]
   end

   // sync flag register; only a status read or reset lowers it
   // so an unread interrupt is never lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync_flag_q <= 1'b0;
      end else begin
         sync_flag_q <= sync_flag_d;
      end
   end

   // read mux, data stand in the cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `SYNC_ADDR_STATUS_THREE: rdata_d[`STAT_SYNC_BIT] = sync_flag_q;
            `SYNC_ADDR_MASK:         rdata_d = mask_q;
            `SYNC_ADDR_BUFFER_LO:    rdata_d = buffer_q[15:0];
            `SYNC_ADDR_BUFFER_HI:    rdata_d = buffer_q[31:16];
            default:                 rdata_d = 16'h0000;
         endcase
      end
   end

   // read data register; zero outside the answer cycle
   // keeps a shared bus quiet when this axis is not addressed
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q     <= 16'h0000;
      end else begin
         rdata_q     <= rdata_d;
      end
   end

   // action pulses come one cycle after the event, from flops
   assign sync_fire                     = act_pulse_q != '0;
   assign fixed_drive_plus_action       = act_pulse_q[`ACT_FIXED_PLUS];   // [R1]
   assign fixed_drive_minus_action      = act_pulse_q[`ACT_FIXED_MINUS];
   assign continuous_drive_plus_action  = act_pulse_q[`ACT_CONT_PLUS];
   assign continuous_drive_minus_action = act_pulse_q[`ACT_CONT_MINUS];
   assign decel_stop_action             = act_pulse_q[`ACT_DECEL_STOP];   // [R6]
   assign instant_stop_action           = act_pulse_q[`ACT_INSTANT_STOP];
   assign logical_pos_load_action       = act_pulse_q[`ACT_LOGICAL_LOAD];
   assign real_pos_load_action          = act_pulse_q[`ACT_REAL_LOAD];    // [R2]
   assign pulse_count_load_action       = act_pulse_q[`ACT_PULSE_LOAD];   // [R3]
   assign speed_load_action             = act_pulse_q[`ACT_SPEED_LOAD];
   assign sync_pulse_out                = act_pulse_q[`ACT_PULSE_OUT];
   assign load_value                    = load_q;
   assign reg_rdata                     = rdata_q;
   // mask reset keeps the sync flag routed to the pin by default
   assign irq_out_n = !(sync_flag_q && mask_q[`STAT_SYNC_BIT]);       // [R4] [R5]
endmodule

// ### pkg/sync_action_map.svh
// register offsets, bit positions and reset values of the synchronous action stage
`ifndef SYNC_ACTION_MAP_SVH
`define SYNC_ACTION_MAP_SVH

// register addresses on the plain register port
`define SYNC_ADDR_FACTOR_LO     4'h0
`define SYNC_ADDR_ACTION_HI     4'h1
`define SYNC_ADDR_MODE_CMD      4'h2
`define SYNC_ADDR_STATUS_THREE  4'h3
`define SYNC_ADDR_MASK          4'h4
`define SYNC_ADDR_BUFFER_LO     4'h5
`define SYNC_ADDR_BUFFER_HI     4'h6

// command codes
`define SYNC_CMD_MODE_SET       8'h64
`define SYNC_CMD_LOGICAL_READ   8'h10

// action select bit positions
`define ACT_FIXED_PLUS          0
`define ACT_FIXED_MINUS         1
`define ACT_CONT_PLUS           2
`define ACT_CONT_MINUS          3
`define ACT_DECEL_STOP          4
`define ACT_INSTANT_STOP        5
`define ACT_LOGICAL_SAVE        6
`define ACT_REAL_SAVE           7
`define ACT_LOGICAL_LOAD        8
`define ACT_REAL_LOAD           9
`define ACT_PULSE_LOAD          10
`define ACT_SPEED_LOAD          11
`define ACT_PULSE_OUT           14
`define ACT_IRQ                 15

// factor select bit positions
`define FAC_LOGICAL_READ        8
`define FAC_COMMAND             9
`define FAC_OTHER_LO            13

// status three bit positions
`define STAT_SYNC_BIT           9

// reset values
`define SYNC_SEL_RESET          16'h0000
`define SYNC_MASK_RESET         16'h0200

`endif

// ### pkg/sync_action_pkg.sv
// types shared by the synchronous action stage
package sync_action_pkg;
   typedef enum logic [1:0] {
      ARM_IDLE  = 2'b00,
      ARM_READY = 2'b01
   } arm_state_type;
endpackage

// ### dv/sync_action_executor_asserts.sv
// port checker of the synchronous action stage
`timescale 1ns/100ps
module sync_action_executor_asserts (
   input wire logic        sys_clk,                 // clock
   input wire logic        rst_n,                   // reset, low
   input wire logic [3:0]  reg_addr,                // address
   input wire logic        reg_wr,                  // write
   input wire logic        reg_rd,                  // read
   input wire logic [15:0] reg_rdata,               // read data
   input wire logic [7:0]  factor_events,           // own events
   input wire logic [2:0]  other_axis_fire,         // linked fires
   input wire logic        sync_fire,               // fired
   input wire logic        fixed_drive_plus_action, // drive start
   input wire logic        real_pos_load_action,    // load
   input wire logic        sync_pulse_out,          // ext pulse
   input wire logic        irq_out_n                // interrupt
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // status read, then the same read with no set racing it
   sequence status_read;
      reg_rd && reg_addr == 4'h3;
   endsequence
   sequence ack_read;
      status_read ##0 (factor_events == 8'h00 && other_axis_fire == 3'h0);
   endsequence
   AST_ACT_FIRE: assert property ((fixed_drive_plus_action || real_pos_load_action
      || sync_pulse_out) |-> sync_fire) else $error("action without fire");
   AST_FIRE_CAUSE: assert property (sync_fire |-> $past(factor_events != 8'h00
      || other_axis_fire != 3'h0 || reg_wr)) else $error("fire without source");
   AST_IRQ_FALL: assert property ($fell(irq_out_n) |-> sync_fire || $past(sync_fire)
      || $past(reg_wr)) else $error("irq without cause");
   AST_IRQ_HOLD: assert property (!irq_out_n && !reg_rd && !reg_wr |=> !irq_out_n)
      else $error("irq dropped");
   AST_READ_ACK: assert property (ack_read |=> irq_out_n) else $error("irq kept");
   AST_READ_FLAG: assert property (status_read ##0 !irq_out_n |=> reg_rdata[9])
      else $error("flag not read");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("stray read data");
   AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=> irq_out_n
      && reg_rdata == 16'h0000 && !sync_fire) else $error("reset not quiet");
endmodule
bind sync_action_executor sync_action_executor_asserts sync_action_executor_asserts_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .factor_events(factor_events), .other_axis_fire(other_axis_fire),
   .sync_fire(sync_fire), .fixed_drive_plus_action(fixed_drive_plus_action),
   .real_pos_load_action(real_pos_load_action), .sync_pulse_out(sync_pulse_out),
   .irq_out_n(irq_out_n));

// ### dv/sync_action_executor_tb.sv
// self-checking bench of the synchronous action stage
`timescale 1ns/100ps
module sync_action_executor_tb;
   logic        sys_clk, rst_n, reg_wr, reg_rd, sync_fire, sync_pulse_out, irq_out_n;
   logic [3:0]  reg_addr, ld;
   logic [15:0] reg_wdata, reg_rdata, lfsr_q, lo;
   logic [7:0]  factor_events;
   logic [2:0]  other_axis_fire;
   logic [5:0]  drv;
   logic [31:0] logical_pos, real_pos, load_value, ex;
   int          fails, cmp_count;
   logic [15:0] model_q[$];
   int          bits[12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 14, 15};
   sync_action_executor sync_action_executor_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .factor_events(factor_events),
      .other_axis_fire(other_axis_fire), .logical_pos(logical_pos), .real_pos(real_pos),
      .sync_fire(sync_fire), .fixed_drive_plus_action(drv[0]),
      .fixed_drive_minus_action(drv[1]), .continuous_drive_plus_action(drv[2]),
      .continuous_drive_minus_action(drv[3]), .decel_stop_action(drv[4]),
      .instant_stop_action(drv[5]), .logical_pos_load_action(ld[0]),
      .real_pos_load_action(ld[1]), .pulse_count_load_action(ld[2]),
      .speed_load_action(ld[3]), .load_value(load_value), .sync_pulse_out(sync_pulse_out),
      .irq_out_n(irq_out_n));
   // 16-bit lfsr feeding staged words and counters
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // strobes drop one edge later, so calls never collide
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask
   task automatic arm(input logic [15:0] f, input logic [15:0] h);
      wr(4'h0, f);
      wr(4'h1, h);
      wr(4'h2, 16'h0064);
   endtask
   task automatic fire(input logic [7:0] e, input logic [2:0] o);
      @(posedge sys_clk);
      factor_events <= e;
      other_axis_fire <= o;
      @(posedge sys_clk);
      factor_events <= 8'h00;
      other_axis_fire <= 3'h0;
      #1;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // hang guard, far beyond the few hundred cycles used
   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, factor_events, other_axis_fire} = '0;
      lfsr_q = 16'h003A;
      logical_pos = 32'h0000_0000;
      real_pos = 32'h0000_0000;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(4'h4, 16'hFFFF, 16'h0200);
      fire(8'hFF, 3'h7);
      chk(sync_fire, 1'b0);
      // every action except the two saves, disabled sources first, then the enabled one
      for (int i = 0; i < 12; i++) begin
         lfsr_q = nxt(lfsr_q);
         lo = (lfsr_q & 16'h1C00) | (16'h0001 << (i % 8));
         arm(lo, 16'h0001 << bits[i]);
         fire(~lo[7:0], 3'h0);
         chk(sync_fire, 1'b0);
         fire(lo[7:0], 3'h0);
         chk({~irq_out_n, sync_pulse_out, 2'b00, ld, 2'b00, drv}, 32'h1 << bits[i]);
         if (bits[i] inside {8, 9, 10}) chk(load_value, {16'h0001 << bits[i], lo});
         if (bits[i] == 11) chk(load_value, {16'h0000, lo});
         if (bits[i] == 15) rd(4'h3, 16'h0200, 16'h0200);
         chk(irq_out_n, 1'b1);
      end
      $display("action set test done");
      // linked axes, interrupt masked then unmasked, then acknowledged
      for (int k = 0; k < 3; k++) begin
         arm(16'h2000 << k, 16'h8000);
         wr(4'h4, 16'h0000);
         fire(8'h00, 3'h1 << k);
         chk(irq_out_n, 1'b1);
         wr(4'h4, 16'h0200);
         #1 chk(irq_out_n, 1'b0);
         rd(4'h3, 16'h0200, 16'h0200);
         chk(irq_out_n, 1'b1);
      end
      $display("linked axis test done");
      // logical read command as trigger, saves into the buffer
      for (int s = 0; s < 2; s++) begin
         arm(16'h0100, 16'h0040 << s);
         lfsr_q = nxt(lfsr_q);
         ex = s ? {~lfsr_q, lfsr_q} : {lfsr_q, ~lfsr_q};
         @(posedge sys_clk);
         logical_pos <= {lfsr_q, ~lfsr_q};
         real_pos <= {~lfsr_q, lfsr_q};
         wr(4'h2, 16'h0010);
         #1 chk(sync_fire, 1'b1);
         model_q.push_back(ex[15:0]);
         model_q.push_back(ex[31:16]);
         rd(4'h5, 16'hFFFF, model_q.pop_front());
         rd(4'h6, 16'hFFFF, model_q.pop_front());
      end
      // command trigger: codes other than arm and logical read fire it
      arm(16'h0200, 16'h0008);
      wr(4'h2, 16'h0010);
      #1 chk(sync_fire, 1'b0);
      lfsr_q = nxt(lfsr_q);
      wr(4'h2, {8'h00, 8'h80 | lfsr_q[7:0]});
      #1 chk(drv, 6'h08);
      $display("command trigger test done");
      rd(4'hF, 16'hFFFF, 16'h0000);
      $display("save and unmapped test done");
      give_verdict();
   end
endmodule
